// ==== bench/dpr_sensor_model.sv ====
/*
  dpr_sensor_model: sensor readout source, one 4x3 frame per start pulse.
  Assumes the block takes a pixel on an edge with valid and in_ready high.
*/
`timescale 1ns/1ps
module dpr_sensor_model (
  // clock and reset
  input  wire                clk,
  input  wire                arst_n,
  // control
  input  wire                start,
  input  wire [11:0]         base,
  output logic               busy,
  // stream
  input  wire                in_ready,
  output dpr_pkg::dpr_pix_t  pix_in
);
  logic [3:0] cnt_ff;

  // pixel i of a 4 wide frame, data is base plus index
  function automatic dpr_pkg::dpr_pix_t mk(logic [3:0] i);
    return '{1'b1, i == 4'h0, i[1:0] == 2'h3, i == 4'hB, base + 12'(i)};
  endfunction

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      pix_in <= '0;
      cnt_ff <= 4'h0;
      busy   <= 1'b0;
    end
    else if (start && !busy)
    begin
      busy   <= 1'b1;
      cnt_ff <= 4'h0;
      pix_in <= mk(4'h0);
    end
    else if (busy && in_ready)
    begin
      // released lines show inverted data, never the last value
      if (cnt_ff == 4'hB)
      begin
        busy   <= 1'b0;
        pix_in <= '{1'b0, 1'b0, 1'b0, 1'b0, ~pix_in.data};
      end
      else
      begin
        cnt_ff <= cnt_ff + 4'h1;
        pix_in <= mk(cnt_ff + 4'h1);
      end
    end
endmodule // dpr_sensor_model

// ==== bench/tb.sv ====
/*
  tb: frame-level tests of dpr_core fed by dpr_sensor_model.
  Assumes the 4x3 frame of the model; pixel index is row*4+col.
*/
`timescale 1ns/1ps
module tb;
  logic               clk;
  logic               arst_n;
  dpr_pkg::dpr_mode_t   mode;
  dpr_pkg::dpr_map_wr_t map_wr;
  dpr_pkg::dpr_pix_t    pix_in;
  dpr_pkg::dpr_pix_t    pix_out;
  logic               in_ready;
  logic               start;
  logic               busy;
  logic [11:0]        base;
  int                 bad_count;
  int                 total_checks;
  int                 cycles;
  int                 out_n;
  logic [11:0]        ref_base;
  localparam int      TIMEOUT_CYCLES = 3000;
  dpr_pkg::dpr_pix_t    got [12];
  logic [11:0]        exp_d [12];
  logic               skip [12];

  dpr_core dut_u (.clk(clk), .arst_n(arst_n), .mode(mode), .map_wr(map_wr),
    .pix_in(pix_in), .in_ready(in_ready), .pix_out(pix_out));
  dpr_sensor_model src_u (.clk(clk), .arst_n(arst_n), .start(start), .base(base),
    .busy(busy), .in_ready(in_ready), .pix_in(pix_in));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cycle count; the ceiling cuts a hang short
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cycles <= 0;
    else
      cycles <= cycles + 1;
  end

  task automatic chk(string what, logic [11:0] e, logic [11:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask

  task automatic map_put(int k, int p);
    @(posedge clk);
    map_wr <= '{1'b1, 1'b0, 9'(k), 12'(p % 4), 12'(p / 4)};
    @(posedge clk);
    map_wr <= '0;
  endtask

  task automatic map_clear();
    @(posedge clk);
    map_wr <= '{1'b0, 1'b1, 9'h0, 12'h0, 12'h0};
    @(posedge clk);
    map_wr <= '0;
  endtask

  task automatic prep(dpr_pkg::dpr_mode_t m, logic [11:0] b);
    @(posedge clk);
    mode <= m;
    base <= b;
    ref_base = b;
    for (int i = 0; i < 12; i++)
    begin
      exp_d[i] = b + 12'(i);
      skip[i] = 1'b0;
    end
  endtask

  task automatic set_exp(int i, int s);
    exp_d[i] = ref_base + 12'(s);
  endtask

  task automatic run_frame(string name);
    int lows;
    lows = 0;
    out_n = 0;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // sampled at each edge, so every one-cycle valid pulse is seen once
    for (int k = 0; k < 200 && (out_n < 12 || busy); k++)
    begin
      @(posedge clk);
      if (pix_out.valid === 1'b1 && out_n < 12)
      begin
        got[out_n] = pix_out;
        out_n++;
      end
      if (in_ready !== 1'b1)
        lows++;
    end
    chk("count", 12'h00C, 12'(out_n));
    chk("refused cycles", 12'h002, 12'(lows));
    for (int i = 0; i < 12; i++)
    begin
      if (!skip[i])
        chk("data", exp_d[i], got[i].data);
      chk("flags", {9'h0, i == 0, i % 4 == 3, i == 11},
        {9'h0, got[i].sof, got[i].eol, got[i].eof});
    end
    $display("test %s done", name);
  endtask

  // lone bad pixels, 8 bit values
  task automatic t_single();
    map_put(0, 4);
    map_put(1, 11);
    prep(dpr_pkg::DPR_MONO, 12'h010);
    set_exp(4, 5);
    set_exp(11, 10);
    run_frame("mono single");
  endtask

  // bad pairs at every boundary, sources not re-checked
  task automatic t_pair();
    int bl [8] = '{0, 1, 4, 5, 6, 7, 10, 11};
    map_clear();
    for (int k = 0; k < 8; k++)
      map_put(k, bl[k]);
    prep(dpr_pkg::DPR_MONO, 12'h300);
    skip[0] = 1'b1;
    set_exp(1, 2);
    set_exp(4, 3);
    set_exp(5, 6);
    set_exp(6, 5);
    set_exp(7, 8);
    set_exp(10, 9);
    skip[11] = 1'b1;
    run_frame("mono pairs");
  endtask

  task automatic t_bayer();
    map_clear();
    map_put(0, 3);
    map_put(1, 6);
    map_put(2, 5);
    map_put(3, 8);
    prep(dpr_pkg::DPR_BAYER, 12'hA00);
    set_exp(3, 1);
    set_exp(6, 4);
    set_exp(5, 7);
    set_exp(8, 10);
    run_frame("bayer");
  endtask

  // cleared list: stream passes untouched
  task automatic t_clear();
    map_clear();
    prep(dpr_pkg::DPR_MONO, 12'hF00);
    run_frame("empty list");
  endtask

  initial
  begin
    arst_n = 1'b0;
    mode = dpr_pkg::DPR_MONO;
    map_wr = '0;
    start = 1'b0;
    base = 12'h000;
    bad_count = 0;
    total_checks = 0;
    out_n = 0;
    ref_base = 12'h000;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    fork
      begin
        t_single();
        t_pair();
        t_bayer();
        t_clear();
      end
      begin
        wait (cycles >= TIMEOUT_CYCLES);
        $display("timeout after %0d cycles", cycles);
        bad_count++;
      end
    join_any
    disable fork;
    print_verdict();
  end
endmodule // tb

// ==== logic/dpr_core.sv ====
/*
  dpr_core: streaming defective pixel replacement, two pixels of look-ahead.
  Assumes the pixel stream and the list loader run on clk; sof marks the
  first pixel of a frame, eol the last of each row, eof the last of a frame.
*/
`timescale 1ns/1ps
module dpr_core (
  // clock and reset
  input  wire                         clk,
  input  wire                         arst_n,
  // configuration
  input  dpr_pkg::dpr_mode_t          mode,
  input  dpr_pkg::dpr_map_wr_t        map_wr,
  // sensor stream
  input  dpr_pkg::dpr_pix_t           pix_in,
  output logic                        in_ready,
  // corrected stream
  output dpr_pkg::dpr_pix_t           pix_out
);

  typedef struct packed {
    dpr_pkg::dpr_slot_t [dpr_pkg::WIN_LEN-1:0] win;
    logic [dpr_pkg::COL_W-1:0]                 col;
    logic [dpr_pkg::ROW_W-1:0]                 row;
    dpr_pkg::dpr_phase_t                       phase;
    logic                                      in_ready;
    dpr_pkg::dpr_pix_t                         out;
  } dpr_core_state_t;

  dpr_core_state_t               st_ff;
  dpr_core_state_t               nxt_st;
  logic                          take;
  logic                          shift;
  logic                          hit;
  logic [dpr_pkg::COL_W-1:0]     cur_col;
  logic [dpr_pkg::ROW_W-1:0]     cur_row;
  dpr_pkg::dpr_slot_t            c;
  dpr_pkg::dpr_slot_t            a1;
  dpr_pkg::dpr_slot_t            b1;

  assign take    = pix_in.valid && st_ff.in_ready;
  assign shift   = take || st_ff.phase != dpr_pkg::DPR_RUN;
  assign cur_col = pix_in.sof ? dpr_pkg::COL_FIRST : st_ff.col;
  assign cur_row = pix_in.sof ? dpr_pkg::ROW_FIRST : st_ff.row;
  assign c       = st_ff.win[dpr_pkg::CENTER];
  assign a1      = st_ff.win[dpr_pkg::AHEAD1];
  assign b1      = st_ff.win[dpr_pkg::BEHIND1];

  dpr_defect_map u_map (
    .clk           (clk),
    .arst_n        (arst_n),
    .map_wr        (map_wr),
    .defect_column (cur_col),
    .defect_row    (cur_row),
    .hit           (hit)
  );

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.out.valid = 1'b0;
    if (shift)
    begin
      // emit the centre slot; neighbours are raw values, never re-checked
      nxt_st.out.valid = c.valid;
      nxt_st.out.sof   = c.sof;
      nxt_st.out.eol   = c.eol;
      nxt_st.out.eof   = c.eof;
      nxt_st.out.data  = c.data;
      if (c.bad)
      begin
        if (mode == dpr_pkg::DPR_BAYER)
        begin
          if (c.odd && c.eol)
            nxt_st.out.data = st_ff.win[dpr_pkg::BEHIND2].data;
          else if (c.odd)
            nxt_st.out.data = st_ff.win[dpr_pkg::AHEAD2].data;
          else if (c.first)
            nxt_st.out.data = st_ff.win[dpr_pkg::AHEAD2].data;
          else
            nxt_st.out.data = st_ff.win[dpr_pkg::BEHIND2].data;
        end
        else if (c.odd)
        begin
          // bad pair: next pixel in stream order, at a row end the next row start or a stale slot
          if (b1.bad)
            nxt_st.out.data = a1.data;
          else
            nxt_st.out.data = b1.data;
        end
        else
        begin
          // bad pair: previous pixel, at a row start the previous row end, or stale data at frame start
          if (a1.bad)
            nxt_st.out.data = b1.data;
          else
            nxt_st.out.data = a1.data;
        end
      end
      for (int i = dpr_pkg::WIN_LEN - 1; i > 0; i--)
        nxt_st.win[i] = st_ff.win[i-1];
      // during flush the data is left stale on purpose
      nxt_st.win[dpr_pkg::AHEAD2].valid = take;
      if (take)
      begin
        nxt_st.win[dpr_pkg::AHEAD2].bad   = hit;
        nxt_st.win[dpr_pkg::AHEAD2].first = cur_col == dpr_pkg::COL_FIRST;
        nxt_st.win[dpr_pkg::AHEAD2].odd   = cur_col[0];
        nxt_st.win[dpr_pkg::AHEAD2].sof   = pix_in.sof;
        nxt_st.win[dpr_pkg::AHEAD2].eol   = pix_in.eol;
        nxt_st.win[dpr_pkg::AHEAD2].eof   = pix_in.eof;
        nxt_st.win[dpr_pkg::AHEAD2].data  = pix_in.data;
        nxt_st.col = pix_in.eol ? dpr_pkg::COL_FIRST : cur_col + dpr_pkg::COL_STEP;
        nxt_st.row = pix_in.eol ? cur_row + dpr_pkg::ROW_STEP : cur_row;
      end
    end
    // three shifts drain the look-ahead; the third already takes a new pixel
    unique case (st_ff.phase)
      dpr_pkg::DPR_RUN, dpr_pkg::DPR_FLUSH3:
        nxt_st.phase = (take && pix_in.eof) ? dpr_pkg::DPR_FLUSH1 : dpr_pkg::DPR_RUN;
      dpr_pkg::DPR_FLUSH1:
        nxt_st.phase = dpr_pkg::DPR_FLUSH2;
      dpr_pkg::DPR_FLUSH2:
        nxt_st.phase = dpr_pkg::DPR_FLUSH3;
    endcase
    nxt_st.in_ready = nxt_st.phase == dpr_pkg::DPR_RUN || nxt_st.phase == dpr_pkg::DPR_FLUSH3;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign in_ready = st_ff.in_ready;
  assign pix_out  = st_ff.out;

  property p_clean_pass;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && !c.bad |=> pix_out.valid && pix_out.data == $past(c.data);
  endproperty
  a_clean_pass: assert property (p_clean_pass) else $error("clean pixel altered");

  property p_mono_even;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_MONO && c.bad && !c.odd && !a1.bad
    |=> pix_out.data == $past(a1.data);
  endproperty
  a_mono_even: assert property (p_mono_even) else $error("lone even not from odd");

  property p_mono_odd;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_MONO && c.bad && c.odd && !b1.bad
    |=> pix_out.data == $past(b1.data);
  endproperty
  a_mono_odd: assert property (p_mono_odd) else $error("lone odd not from even");

  property p_pair_even;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_MONO && c.bad && !c.odd && a1.bad
    |=> pix_out.data == $past(b1.data);
  endproperty
  a_pair_even: assert property (p_pair_even) else $error("pair even source wrong");

  property p_pair_odd;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_MONO && c.bad && c.odd && b1.bad
    |=> pix_out.data == $past(a1.data);
  endproperty
  a_pair_odd: assert property (p_pair_odd) else $error("pair odd source wrong");

  property p_bayer_even;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_BAYER && c.bad && !c.odd && !c.first
    |=> pix_out.data == $past(st_ff.win[dpr_pkg::BEHIND2].data);
  endproperty
  a_bayer_even: assert property (p_bayer_even) else $error("bayer even source wrong");

  property p_bayer_odd;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_BAYER && c.bad && c.odd && !c.eol
    |=> pix_out.data == $past(st_ff.win[dpr_pkg::AHEAD2].data);
  endproperty
  a_bayer_odd: assert property (p_bayer_odd) else $error("bayer odd source wrong");

  property p_bayer_first;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_BAYER && c.bad && c.first && !c.odd
    |=> pix_out.data == $past(st_ff.win[dpr_pkg::AHEAD2].data);
  endproperty
  a_bayer_first: assert property (p_bayer_first) else $error("line start source wrong");

  property p_bayer_last;
    @(posedge clk) disable iff (!arst_n)
    shift && c.valid && mode == dpr_pkg::DPR_BAYER && c.bad && c.odd && c.eol
    |=> pix_out.data == $past(st_ff.win[dpr_pkg::BEHIND2].data);
  endproperty
  a_bayer_last: assert property (p_bayer_last) else $error("line end source wrong");

  property p_flush;
    @(posedge clk) disable iff (!arst_n)
    take && pix_in.eof |=> !in_ready ##1 !in_ready ##1 in_ready;
  endproperty
  a_flush: assert property (p_flush) else $error("frame end flush length wrong");

  property p_drain;
    @(posedge clk) disable iff (!arst_n)
    take && pix_in.eof |=> ##2 st_ff.phase == dpr_pkg::DPR_FLUSH3 ##1 pix_out.valid && pix_out.eof;
  endproperty
  a_drain: assert property (p_drain) else $error("last frame pixel not drained");

endmodule // dpr_core

// ==== logic/dpr_defect_map.sv ====
/*
  dpr_defect_map: flip-flop store of defect coordinates with a parallel match.
  Assumes the loader writes the chosen list (factory or user) between frames.
*/
`timescale 1ns/1ps
module dpr_defect_map (
  // clock and reset
  input  wire                         clk,
  input  wire                         arst_n,
  // list load
  input  dpr_pkg::dpr_map_wr_t        map_wr,
  // lookup
  input  wire [dpr_pkg::COL_W-1:0]    defect_column,
  input  wire [dpr_pkg::ROW_W-1:0]    defect_row,
  output logic                        hit
);

  typedef struct packed {
    dpr_pkg::dpr_entry_t [dpr_pkg::MAP_DEPTH-1:0] ent;
  } dpr_map_state_t;

  dpr_map_state_t                   st_ff;
  dpr_map_state_t                   nxt_st;
  logic [dpr_pkg::MAP_DEPTH-1:0]    match;

  // capacity is fixed; entries past the loaded ones stay unused
  always_comb
  begin
    nxt_st = st_ff;
    if (map_wr.clear)
    begin
      for (int i = 0; i < dpr_pkg::MAP_DEPTH; i++)
        nxt_st.ent[i].used = 1'b0;
    end
    if (map_wr.we)
      nxt_st.ent[map_wr.idx] = {1'b1, map_wr.col, map_wr.row};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // origin is the upper left pixel of the frame
  genvar g;
  generate
    for (g = 0; g < dpr_pkg::MAP_DEPTH; g++)
    begin : g_match
      assign match[g] = st_ff.ent[g].used && st_ff.ent[g].col == defect_column
                        && st_ff.ent[g].row == defect_row;
    end
  endgenerate

  assign hit = |match;

endmodule // dpr_defect_map

// ==== logic/dpr_pkg.sv ====
/*
  dpr_pkg: constants and carrier types of the defective pixel replacement block.
  Assumes one 10 MHz clock and that pixel streams sit in the low bits of PIX_W.
*/
package dpr_pkg;

  localparam int unsigned PIX_W     = 12;
  localparam int unsigned COL_W     = 12;
  localparam int unsigned ROW_W     = 12;
  localparam int unsigned MAP_DEPTH = 512;
  localparam int unsigned IDX_W     = 9;
  localparam int unsigned WIN_LEN   = 5;

  // window slots, relative to the pixel being emitted
  localparam int unsigned AHEAD2  = 0;
  localparam int unsigned AHEAD1  = 1;
  localparam int unsigned CENTER  = 2;
  localparam int unsigned BEHIND1 = 3;
  localparam int unsigned BEHIND2 = 4;

  localparam logic [COL_W-1:0] COL_FIRST = 12'h000;
  localparam logic [COL_W-1:0] COL_STEP  = 12'h001;
  localparam logic [ROW_W-1:0] ROW_FIRST = 12'h000;
  localparam logic [ROW_W-1:0] ROW_STEP  = 12'h001;

  typedef enum logic {DPR_MONO, DPR_BAYER} dpr_mode_t;

  typedef enum logic [1:0] {DPR_RUN, DPR_FLUSH1, DPR_FLUSH2, DPR_FLUSH3} dpr_phase_t;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    logic             eof;
    logic [PIX_W-1:0] data;
  } dpr_pix_t;

  typedef struct packed {
    logic             we;
    logic             clear;
    logic [IDX_W-1:0] idx;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
  } dpr_map_wr_t;

  typedef struct packed {
    logic             used;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
  } dpr_entry_t;

  typedef struct packed {
    logic             valid;
    logic             bad;
    logic             first;
    logic             odd;
    logic             sof;
    logic             eol;
    logic             eof;
    logic [PIX_W-1:0] data;
  } dpr_slot_t;

endpackage
